// ### src/spimsb_pkg.sv
// Package for the byte-wide serial port: register map, fields, counts.
// Assumes both ends and the bench import it.
package spimsb_pkg;
  // Register addresses of the controller end (own choice)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_DATA = 4'h2;
  localparam logic [3:0] ADDR_DIR = 4'h3;
  // Control bits
  localparam int CTRL_RATE0 = 0;
  localparam int CTRL_RATE1 = 1;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_MASTER_SELECT_BIT = 4;
  localparam int CTRL_LSBF = 5;
  localparam int CTRL_EN = 6;
  localparam int CTRL_IE = 7;
  // Status bits
  localparam int STAT_X2 = 0;
  localparam int STAT_WCOL = 6;
  localparam int STAT_DONE = 7;
  // Direction bits, one per pin: 0 mosi, 1 miso, 2 sck, 3 ss
  localparam int DIR_MOSI = 0;
  localparam int DIR_MISO = 1;
  localparam int DIR_SCK = 2;
  localparam int DIR_SS = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int BYTE_BITS = 8;
  // Half-period of serial clock in system cycles per rate code {x2,r1,r0}
  localparam logic [7:0] HALF_DIV2 = 8'h01;
  localparam logic [7:0] HALF_DIV4 = 8'h02;
  localparam logic [7:0] HALF_DIV8 = 8'h04;
  localparam logic [7:0] HALF_DIV16 = 8'h08;
  localparam logic [7:0] HALF_DIV32 = 8'h10;
  localparam logic [7:0] HALF_DIV64 = 8'h20;
  localparam logic [7:0] HALF_DIV128 = 8'h40;
  // Far-end master half period in system cycles (must exceed 2)
  localparam logic [7:0] FAR_HALF = 8'h04;
endpackage

// ### src/spimsb_if.sv
// Interface carrying the four serial lines between the two ends.
// Assumes each line is resolved here from drive values and enables.
`timescale 1ns/1ps
interface spimsb_if;
  // Device end drives, enables active low
  logic dev_mosi_o, dev_mosi_oe_n;
  logic dev_miso_o, dev_miso_oe_n;
  logic dev_sck_o, dev_sck_oe_n;
  logic dev_ss_o, dev_ss_oe_n;
  // Far end drives
  logic far_mosi_o, far_mosi_oe_n;
  logic far_miso_o, far_miso_oe_n;
  logic far_sck_o, far_sck_oe_n;
  logic far_ss_o, far_ss_oe_n;
  // Resolved line levels; undriven data and select lines idle high, clock idles low
  logic mosi, miso, sck, ss_n;
  assign mosi = !dev_mosi_oe_n ? dev_mosi_o :
                !far_mosi_oe_n ? far_mosi_o : 1'b1;
  assign miso = !dev_miso_oe_n ? dev_miso_o :
                !far_miso_oe_n ? far_miso_o : 1'b1;
  assign sck = !dev_sck_oe_n ? dev_sck_o :
               !far_sck_oe_n ? far_sck_o : 1'b0;
  assign ss_n = !dev_ss_oe_n ? dev_ss_o :
                !far_ss_oe_n ? far_ss_o : 1'b1;
  modport dev (
    output dev_mosi_o, dev_mosi_oe_n, dev_miso_o, dev_miso_oe_n,
    output dev_sck_o, dev_sck_oe_n, dev_ss_o, dev_ss_oe_n,
    input mosi, miso, sck, ss_n
  );
  modport far (
    output far_mosi_o, far_mosi_oe_n, far_miso_o, far_miso_oe_n,
    output far_sck_o, far_sck_oe_n, far_ss_o, far_ss_oe_n,
    input mosi, miso, sck, ss_n
  );
endinterface

// ### src/spimsb_far.sv
// Far end: a plain master that selects the device, swaps one byte
// per request and releases select on request; mode 0, MSB first.
// Assumes the device end is a slave when this end runs.
`timescale 1ns/1ps
module spimsb_far
  import spimsb_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Link
  spimsb_if.far lnk,
  // User side
  input wire logic sel_i,
  input wire logic start_i,
  input wire logic [7:0] tx_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_o
);
  import spimsb_pkg::*;

  logic [7:0] div_r, sh_r, rx_r;
  logic [3:0] cnt_r;
  logic sck_r, busy_r, done_r, ss_r, miso_s1_r, miso_s2_r;
  // Each clock phase lasts FAR_HALF cycles; see RQ15
  wire tick = (div_r == FAR_HALF - 8'h01);

  // Select only under user control, high between packets; see RQ1
  assign lnk.far_ss_o = ss_r;
  assign lnk.far_ss_oe_n = 1'b0;
  assign lnk.far_sck_o = sck_r;
  assign lnk.far_sck_oe_n = 1'b0;
  // Master drives MOSI only; see RQ2
  assign lnk.far_mosi_o = sh_r[7];
  assign lnk.far_mosi_oe_n = 1'b0;
  assign lnk.far_miso_o = 1'b1;
  assign lnk.far_miso_oe_n = 1'b1;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign rx_o = rx_r;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_r <= 8'h00;
      sh_r <= 8'h00;
      rx_r <= 8'h00;
      cnt_r <= 4'h0;
      sck_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ss_r <= 1'b1;
      miso_s1_r <= 1'b1;
      miso_s2_r <= 1'b1;
    end
    else
    begin
      miso_s1_r <= lnk.miso;
      miso_s2_r <= miso_s1_r;
      done_r <= 1'b0;
      ss_r <= ~sel_i;
      if (!busy_r && start_i && sel_i)
      begin
        // Next byte or end of packet is the user's choice; see RQ7
        sh_r <= tx_i;
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
        div_r <= 8'h00;
      end
      else if (busy_r)
      begin
        div_r <= tick ? 8'h00 : div_r + 8'h01;
        if (tick)
        begin
          sck_r <= ~sck_r;
          if (sck_r)
          begin
            // Late sample, just before the fall: covers both synchronisers
            rx_r <= {rx_r[6:0], miso_s2_r};
            sh_r <= {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(BYTE_BITS - 1))
            begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule

// ### src/spimsb_dev.sv
// Device end: byte serial port working as master or slave.
// Assumes a plain register port on clock_i and the link of spimsb_if.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Master lowers select per packet, raises after
// RQ2 - MOSI carries master data, MISO slave data
// RQ3 - Master select line is software driven only
// RQ4 - Data write in master starts eight-bit shift
// RQ5 - After byte, clock stops and done flag sets
// RQ6 - Done flag with enable raises interrupt request
// RQ7 - Master reloads data or releases select
// RQ8 - Last received byte stays readable in buffer
// RQ9 - Slave idle, MISO released while select high
// RQ10 - Slave preloads data; shifts only when selected
// RQ11 - Slave sets done flag after full byte
// RQ12 - Slave may load next byte before reading
// RQ13 - No transmit holding buffer beyond shifter
// RQ14 - Receive double buffered; unread byte overwritten
// RQ15 - Far master keeps clock phases over two cycles
// RQ16 - Enabled port forces pin directions per role
// RQ17 - Bit order selectable, LSB or MSB first
// RQ18 - Seven master rates, double speed at half
// RQ19 - Enable, master, rate0 give sixteenth clock
// RQ20 - Done interrupt can wake idle processor
// RQ21 - Slave select rise resets shift logic
// RQ22 - Master with select input low becomes slave
// RQ23 - Data write during transfer sets collision flag
module spimsb_dev
  import spimsb_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Requests
  output logic irq_o,
  output logic wake_o,
  // User levels of pins the port does not override
  input wire logic [3:0] user_out_i,
  // Link
  spimsb_if.dev lnk
);
  import spimsb_pkg::*;

  // --------------------------------------------------------------
  // Registers and synchronisers
  // --------------------------------------------------------------
  logic [7:0] ctrl_r, data_r, rxbuf_r, rdata_r, div_r;
  logic [3:0] dir_r, cnt_r;
  logic x2_r, done_r, wcol_r, busy_r, sck_r;
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic ss_s1_r, ss_s2_r;
  logic mosi_s1_r, mosi_s2_r, miso_s1_r, miso_s2_r;
  logic smp_r;

  wire en = ctrl_r[CTRL_EN];
  wire master_select_bit = ctrl_r[CTRL_MASTER_SELECT_BIT];
  wire lsbf = ctrl_r[CTRL_LSBF];
  wire master = en && master_select_bit;
  wire slave = en && !master_select_bit;
  wire sel = slave && !ss_s2_r;
  wire wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
  wire wr_stat = wr_i && (addr_i == ADDR_STAT);
  wire wr_data = wr_i && (addr_i == ADDR_DATA);
  wire wr_dir = wr_i && (addr_i == ADDR_DIR);
  wire rd_stat = rd_i && (addr_i == ADDR_STAT);
  wire rd_data = rd_i && (addr_i == ADDR_DATA);

  // --------------------------------------------------------------
  // Rate select
  // --------------------------------------------------------------
  logic [7:0] half;
  // Seven rates; rate0 alone gives a sixteenth; see RQ18 RQ19
  always_comb
  begin
    unique case ({x2_r, ctrl_r[CTRL_RATE1], ctrl_r[CTRL_RATE0]})
      3'b000: half = HALF_DIV4;
      3'b001: half = HALF_DIV16;
      3'b010: half = HALF_DIV64;
      3'b011: half = HALF_DIV128;
      3'b100: half = HALF_DIV2;
      3'b101: half = HALF_DIV8;
      3'b110: half = HALF_DIV32;
      3'b111: half = HALF_DIV64;
    endcase
  end
  wire tick = busy_r && master && (div_r == half - 8'h01);

  // Edges of the sampled slave clock, from the settled stages only
  wire s_rise = sck_s2_r && !sck_s3_r;
  wire s_fall = !sck_s2_r && sck_s3_r;
  wire m_lead = tick && !sck_r;
  wire m_trail = tick && sck_r;
  wire lead = master ? m_lead : (sel && s_rise);
  wire trail = master ? m_trail : (sel && s_fall);
  wire in_bit = master ? miso_s2_r : mosi_s2_r;
  wire last = trail && (cnt_r == 4'(BYTE_BITS - 1));
  // Bit order choice on both ends of shifter; see RQ17
  wire out_bit = lsbf ? data_r[0] : data_r[7];
  wire [7:0] shifted = lsbf ? {smp_r, data_r[7:1]}
                            : {data_r[6:0], smp_r};
  // Mode fault: select input low while master; see RQ22
  wire mfault = master && dir_r[DIR_SS] == 1'b0 && !ss_s2_r;

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // Forced directions while enabled; see RQ16
  assign lnk.dev_mosi_oe_n = !(en ? (master_select_bit && dir_r[DIR_MOSI])
                                  : dir_r[DIR_MOSI]);
  assign lnk.dev_sck_oe_n = !(en ? (master_select_bit && dir_r[DIR_SCK])
                                 : dir_r[DIR_SCK]);
  // Slave MISO released unless selected; see RQ9
  assign lnk.dev_miso_oe_n = !(en ? (sel && dir_r[DIR_MISO])
                                  : dir_r[DIR_MISO]);
  // Select line is a plain user output in master role; see RQ3
  assign lnk.dev_ss_oe_n = !((!en || master_select_bit) && dir_r[DIR_SS]);
  assign lnk.dev_ss_o = user_out_i[DIR_SS];
  // Data out on separate lines per direction; see RQ2
  assign lnk.dev_mosi_o = master ? out_bit : user_out_i[DIR_MOSI];
  assign lnk.dev_miso_o = slave ? out_bit : user_out_i[DIR_MISO];
  assign lnk.dev_sck_o = master ? sck_r : user_out_i[DIR_SCK];

  // Done with enable requests interrupt and idle wake; see RQ6 RQ20
  assign irq_o = done_r && ctrl_r[CTRL_IE];
  assign wake_o = irq_o;
  assign rdata_o = rdata_r;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      ss_s1_r <= 1'b1;
      ss_s2_r <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end
    else
    begin
      sck_s1_r <= lnk.sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      ss_s1_r <= lnk.ss_n;
      ss_s2_r <= ss_s1_r;
      mosi_s1_r <= lnk.mosi;
      mosi_s2_r <= mosi_s1_r;
      miso_s1_r <= lnk.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // --------------------------------------------------------------
  // Control, shifter and flags
  // --------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r <= CTRL_RST;
      dir_r <= DIR_RST;
      data_r <= DATA_RST;
      rxbuf_r <= DATA_RST;
      rdata_r <= 8'h00;
      div_r <= 8'h00;
      cnt_r <= 4'h0;
      x2_r <= 1'b0;
      done_r <= 1'b0;
      wcol_r <= 1'b0;
      busy_r <= 1'b0;
      sck_r <= 1'b0;
      smp_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rd_stat ? {done_r, wcol_r, 5'h00, x2_r}
               : rd_data ? rxbuf_r
               : rd_i && addr_i == ADDR_CTRL ? ctrl_r
               : rd_i && addr_i == ADDR_DIR ? {4'h0, dir_r}
               : 8'h00;
      if (wr_dir)
        dir_r <= wdata_i[3:0];
      if (wr_stat)
        x2_r <= wdata_i[STAT_X2];
      if (mfault)
        ctrl_r[CTRL_MASTER_SELECT_BIT] <= 1'b0;
      else if (wr_ctrl)
        ctrl_r <= wdata_i;
      // Reading the data register clears flags; a new byte wins
      if (rd_data)
      begin
        done_r <= 1'b0;
        wcol_r <= 1'b0;
      end
      if (busy_r)
        div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick)
        sck_r <= ~sck_r;
      if (lead)
        smp_r <= in_bit;
      if (trail)
      begin
        data_r <= shifted;
        cnt_r <= cnt_r + 4'h1;
      end
      if (last)
      begin
        // Clock halts and flag sets per byte; see RQ5 RQ11
        busy_r <= 1'b0;
        cnt_r <= 4'h0;
        done_r <= 1'b1;
        // Old unread byte is overwritten; see RQ8 RQ14
        rxbuf_r <= shifted;
      end
      // Rising select drops partial bits; see RQ21 RQ1
      if (slave && ss_s2_r)
      begin
        cnt_r <= 4'h0;
        busy_r <= 1'b0;
      end
      if (mfault || !en)
      begin
        busy_r <= 1'b0;
        cnt_r <= 4'h0;
        sck_r <= 1'b0;
      end
      if (wr_data)
      begin
        // No holding buffer; write during shift collides; see RQ13 RQ23
        if (busy_r || (sel && cnt_r != 4'h0))
          wcol_r <= 1'b1;
        else
        begin
          // Slave may preload, master starts; see RQ4 RQ10 RQ12 RQ7
          data_r <= wdata_i;
          if (master)
          begin
            busy_r <= 1'b1;
            div_r <= 8'h00;
            cnt_r <= 4'h0;
          end
        end
      end
      // Slave needs slow enough clock phases; see RQ15
      if (sel && !busy_r && (s_rise || s_fall))
        busy_r <= 1'b1;
    end
  end
endmodule

// ### verif/spimsb_properties.sv
// Checker of the serial lines between the device end and the far end.
// Assumes the bench wires it to the interface that joins the two ends.
`timescale 1ns/1ps
module spimsb_properties
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Line enables and levels
  input wire logic dev_mosi_oe_n,
  input wire logic dev_miso_oe_n,
  input wire logic dev_sck_oe_n,
  input wire logic far_sck_oe_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sck,
  input wire logic ss_n
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence s_far_rise;
    $rose(sck) && dev_sck_oe_n && !far_sck_oe_n;
  endsequence
  // Two high samples in a row: no falling edge in between
  sequence s_high_hold;
    sck && $past(sck);
  endsequence
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_far_selects: assert property (s_far_rise |-> !ss_n)
    else $error("Clock rose while no slave was selected");
  chk_sck_phase: assert property (s_far_rise |=> $stable(sck) [*2])
    else $error("Far clock phase too short");
  chk_idle_clock: assert property (
    ss_n && dev_sck_oe_n && !far_sck_oe_n |-> !sck)
    else $error("Clock not low outside a packet");
  // Select passes two synchroniser stages before the output lets go
  chk_slave_quiet: assert property (ss_n && $past(ss_n) &&
    $past(ss_n, 2) && dev_sck_oe_n |-> dev_miso_oe_n)
    else $error("Slave drove its output while deselected");
  chk_slave_mosi_in: assert property (
    dev_sck_oe_n && !dev_miso_oe_n |-> dev_mosi_oe_n)
    else $error("Slave drove the master data line");
  chk_master_miso_in: assert property (
    !dev_sck_oe_n |-> dev_miso_oe_n)
    else $error("Master drove the slave data line");
  chk_mosi_hold: assert property (
    s_high_hold and !dev_mosi_oe_n |-> $stable(mosi))
    else $error("Master data changed while clock high");
  chk_miso_hold: assert property (
    s_high_hold and !dev_miso_oe_n |-> $stable(miso))
    else $error("Slave data changed while clock high");
endmodule

// ### verif/spi_master_slave_byte_port_bench.sv
// Bench joining the device end and the far end over the serial lines.
// Assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module spi_master_slave_byte_port_bench;
  import spimsb_pkg::*;
  logic clock_i, arst_n_i, wr_i, rd_i, irq_o, wake_o;
  logic sel_i, start_i, far_busy, far_done;
  logic sck_q = 1'b0;
  logic [3:0] addr_i, user_out_i;
  logic [7:0] wdata_i, rdata_o, tx_i, far_rx, st, got;
  logic [7:0] cap = 8'h00, per = 8'h00, cnt = 8'h00;
  logic [2:0] code;
  int failures, n_tests;
  localparam logic [7:0] HALF_TAB [8] = '{HALF_DIV4, HALF_DIV16,
    HALF_DIV64, HALF_DIV128, HALF_DIV2, HALF_DIV8, HALF_DIV32, HALF_DIV64};
  localparam logic [3:0] RA [5] = '{ADDR_CTRL, ADDR_STAT, ADDR_DATA,
    ADDR_DIR, 4'h7};
  spimsb_if lnk();
  spimsb_dev spimsb_dev_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o),
    .user_out_i(user_out_i), .lnk(lnk.dev));
  spimsb_far spimsb_far_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .lnk(lnk.far), .sel_i(sel_i), .start_i(start_i), .tx_i(tx_i),
    .busy_o(far_busy), .done_o(far_done), .rx_o(far_rx));
  spimsb_properties spimsb_properties_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .dev_mosi_oe_n(lnk.dev_mosi_oe_n),
    .dev_miso_oe_n(lnk.dev_miso_oe_n), .dev_sck_oe_n(lnk.dev_sck_oe_n),
    .far_sck_oe_n(lnk.far_sck_oe_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .sck(lnk.sck), .ss_n(lnk.ss_n));
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // ---------------------------------------------------------------
  // Line monitor: master data at each clock rise, clock period
  // ---------------------------------------------------------------
  always @(posedge clock_i)
  begin
    sck_q <= lnk.sck;
    cnt <= cnt + 8'h01;
    if (lnk.sck && !sck_q)
    begin
      cap <= {cap[6:0], lnk.mosi};
      per <= cnt;
      cnt <= 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cmp8(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  // Polls status; a status read leaves the flags alone
  task automatic wait_done();
    st = 8'h00;
    for (int k = 0; k < 1000 && st[STAT_DONE] === 1'b0; k++)
    begin
      rd(ADDR_STAT);
      st = got;
    end
  endtask
  task automatic far_xfer(input logic [7:0] b);
    @(posedge clock_i);
    tx_i <= b;
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    for (int k = 0; k < 200 && far_done !== 1'b1; k++)
    begin
      @(posedge clock_i);
      #1;
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Slowest byte is 1024 cycles; the whole run is a few thousand
  initial
  begin
    #(30000 * 25);
    failures++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    {arst_n_i, wr_i, rd_i, sel_i, start_i} = 5'h00;
    {addr_i, wdata_i, tx_i} = 20'h0;
    user_out_i = 4'ha;
    failures = 0;
    n_tests = 0;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int j = 0; j < 5; j++)
    begin
      rd(RA[j]);
      cmp8("reset value", 8'h00, got);
    end
    // Master at every rate; a collision on the second rate
    wr(ADDR_DIR, 8'h05);
    for (int i = 0; i < 8; i++)
    begin
      code = i[2:0];
      wr(ADDR_STAT, {7'h00, code[2]});
      wr(ADDR_CTRL, {6'h34, code[1:0]});
      wr(ADDR_DATA, 8'ha5);
      if (i == 1)
        wr(ADDR_DATA, 8'h00);
      wait_done();
      cmp8("status", {1'b1, i == 1, 5'h00, code[2]}, st);
      cmp8("period", {HALF_TAB[i][6:0], 1'b0}, per);
      cmp8("mosi", 8'ha5, cap);
      cmp1("irq", 1'b1, irq_o);
      cmp1("wake", 1'b1, wake_o);
      rd(ADDR_DATA);
      cmp8("rx", 8'hff, got);
      cmp1("irq cleared", 1'b0, irq_o);
    end
    // Least significant bit first, interrupt disabled
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h71);
    wr(ADDR_DATA, 8'h1e);
    wait_done();
    cmp8("mosi lsb", 8'h78, cap);
    cmp1("irq off", 1'b0, irq_o);
    rd(ADDR_DATA);
    // Slave: preload while deselected, then two bytes unread
    wr(ADDR_CTRL, 8'hc0);
    wr(ADDR_DIR, 8'h02);
    wr(ADDR_DATA, 8'h5a);
    @(posedge clock_i);
    sel_i <= 1'b1;
    far_xfer(8'hc3);
    cmp8("far rx", 8'h5a, far_rx);
    wait_done();
    wr(ADDR_DATA, 8'h96);
    rd(ADDR_DATA);
    cmp8("slave rx", 8'hc3, got);
    far_xfer(8'h11);
    cmp8("far rx", 8'h96, far_rx);
    far_xfer(8'h22);
    wait_done();
    rd(ADDR_DATA);
    cmp8("slave rx", 8'h22, got);
    // Select pulled low under a master with select as input
    @(posedge clock_i);
    sel_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    wr(ADDR_CTRL, 8'h51);
    wr(ADDR_DIR, 8'h05);
    @(posedge clock_i);
    sel_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(ADDR_CTRL);
    cmp8("ctrl", 8'h41, got);
    wrap_up();
  end
endmodule
